// >>> pkg/msc_pkg.sv
// Package of constants and types shared by both ends of the main state control link.
package msc_pkg;
    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int          ADDR_W          = 17;
    localparam logic [16:0] SOFT_RESET_ADDR = 17'h10600;
    localparam logic [16:0] COMMIT_ADDR     = 17'h10601;
    localparam logic [16:0] OW_COMMIT_ADDR  = 17'h10602;
    localparam logic [16:0] GAP_ADDR        = 17'h10603;
    localparam logic [16:0] MAIN_SEL_ADDR   = 17'h10604;
    localparam int          EE_RST_BIT      = 1;
    localparam int          CIPH_RST_BIT    = 0;
    localparam logic [7:0]  SOFT_RESET_RST  = 8'h00;
    localparam logic [3:0]  MAIN_SEL_RST    = 4'h0;
    // ****************************************************************
    // Main state codes
    // ****************************************************************
    localparam logic [3:0] CODE_IDLE      = 4'h1;
    localparam logic [3:0] CODE_CORE      = 4'h5;
    localparam logic [3:0] CODE_SERIAL    = 4'h6;
    localparam logic [3:0] CODE_EE_CFG    = 4'h7;
    localparam logic [3:0] CODE_RANDOM    = 4'h8;
    localparam logic [3:0] CODE_CIPHER    = 4'h9;
    localparam logic [3:0] CODE_KEY_AGREE = 4'hA;
    localparam logic [3:0] CODE_IDENT     = 4'hB;
    localparam logic [3:0] CODE_PERM      = 4'hC;
    localparam logic [3:0] CODE_OVERWRITE = 4'hF;
    // Host software port addresses of the controller's own registers.
    localparam logic [1:0] HOST_CMD_ADDR  = 2'h0;
    localparam logic [1:0] HOST_RST_ADDR  = 2'h1;
    localparam logic [1:0] HOST_STAT_ADDR = 2'h2;

    typedef enum logic [3:0] {
        idle_state, core_control_state, standard_serial_state, eeprom_config_state,
        random_gen_state, symmetric_cipher_state, key_agreement_state,
        identity_readout_state, permission_fetch_state, eeprom_overwrite_state
    } msc_state_t;
endpackage

// >>> pkg/msc_if.sv
// Interface carrying the register port between host controller and device.
`timescale 1ns/100ps
interface msc_if;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> hw/msc_device.sv
// Device end: main state selector, commit strobes and soft reset bits.
//
// Overview of operation
// R01 - EEPROM reset bit: 1 holds reset, 0 runs.
// R02 - Cipher reset bit readable; 1 holds reset.
// R03 - Access locations store nothing; accesses only trigger.
// R04 - Second access location commits overwrite state.
// R05 - Main code bits 3:0, upper reserved, resets zero.
// R06 - Codes 1,5,6,7,8,9 select idle and functions.
// R07 - Codes A,B,C,F select further function states.
// R08 - Host writes code 1 then commits for idle.
// R09 - Host returns to idle between function states.
// R10 - Starts idle; function states alternate with idle.
// R11 - Idle does nothing; function state performs action.
// R12 - No commit or undecoded code: state unchanged.
`timescale 1ns/100ps
module msc_device (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    msc_if.dev                       bus,
    output msc_pkg::msc_state_t      mainState,
    output logic                     functionActive,
    output logic                     eepromReset,
    output logic                     cipherReset
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    // Maps a code to its state; valid is low for undecoded codes.
    function automatic logic decodeCode(input logic [3:0] code, output msc_pkg::msc_state_t st);
        decodeCode = 1'b1;
        st         = msc_pkg::idle_state;
        unique case (code)
            msc_pkg::CODE_IDLE:      st = msc_pkg::idle_state;
            msc_pkg::CODE_CORE:      st = msc_pkg::core_control_state;
            msc_pkg::CODE_SERIAL:    st = msc_pkg::standard_serial_state;
            msc_pkg::CODE_EE_CFG:    st = msc_pkg::eeprom_config_state;
            msc_pkg::CODE_RANDOM:    st = msc_pkg::random_gen_state;
            msc_pkg::CODE_CIPHER:    st = msc_pkg::symmetric_cipher_state;
            msc_pkg::CODE_KEY_AGREE: st = msc_pkg::key_agreement_state;
            msc_pkg::CODE_IDENT:     st = msc_pkg::identity_readout_state;
            msc_pkg::CODE_PERM:      st = msc_pkg::permission_fetch_state;
            msc_pkg::CODE_OVERWRITE: st = msc_pkg::eeprom_overwrite_state;
            default:                 decodeCode = 1'b0;
        endcase
    endfunction

    logic [1:0]          softReset_r;
    logic [3:0]          mainSel_r;
    msc_pkg::msc_state_t state_r;
    msc_pkg::msc_state_t decState;
    logic                decValid;
    logic                commitHit;
    logic                owCommitHit;
    logic [7:0]          rdata_r;

    always_comb begin
        decValid = decodeCode(mainSel_r, decState);
    end

    // Any access, read or write, counts as the trigger.
    assign commitHit   = (bus.wr || bus.rd) && (bus.addr == msc_pkg::COMMIT_ADDR);     // [R03]
    assign owCommitHit = (bus.wr || bus.rd) && (bus.addr == msc_pkg::OW_COMMIT_ADDR);  // [R03]

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            softReset_r <= msc_pkg::SOFT_RESET_RST[1:0];
        end else if (bus.wr && bus.addr == msc_pkg::SOFT_RESET_ADDR) begin
            softReset_r <= bus.wdata[1:0];  // [R01] [R02]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mainSel_r <= msc_pkg::MAIN_SEL_RST;  // [R05]
        end else if (bus.wr && bus.addr == msc_pkg::MAIN_SEL_ADDR) begin
            mainSel_r <= bus.wdata[3:0];  // [R05]
        end
    end

    // ****************************************************************
    // Main state
    // ****************************************************************
    // Writing the code alone never moves the state; a commit is needed.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= msc_pkg::idle_state;  // [R10]
        end else if (commitHit && decValid) begin
            state_r <= decState;  // [R06] [R07] [R12]
        end else if (owCommitHit && mainSel_r == msc_pkg::CODE_OVERWRITE) begin
            state_r <= msc_pkg::eeprom_overwrite_state;  // [R04]
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                msc_pkg::SOFT_RESET_ADDR: rdata_r <= {6'h00, softReset_r};
                msc_pkg::MAIN_SEL_ADDR:   rdata_r <= {4'h0, mainSel_r};  // [R05]
                default:                  rdata_r <= 8'h00;  // [R03]
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign bus.rdata      = rdata_r;
    assign mainState      = state_r;
    assign functionActive = (state_r != msc_pkg::idle_state);  // [R11]
    assign eepromReset    = softReset_r[msc_pkg::EE_RST_BIT];  // [R01]
    assign cipherReset    = softReset_r[msc_pkg::CIPH_RST_BIT];  // [R02]
endmodule

// >>> hw/msc_host.sv
// Host end: sequences main state changes and soft resets from a software port.
`timescale 1ns/100ps
module msc_host (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    msc_if.host              bus,
    input  wire logic [1:0]  swAddr,
    input  wire logic [7:0]  swWdata,
    input  wire logic        swWr,
    input  wire logic        swRd,
    output logic      [7:0]  swRdata
);
    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // A function code is only sent from idle; from a function state the host
    // first goes back to idle, so two function states never follow directly.
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_WR_IDLE, SEQ_COMMIT_IDLE, SEQ_WR_CODE, SEQ_COMMIT, SEQ_RST_SET, SEQ_RST_CLR
    } msc_seq_t;

    msc_seq_t    seq_r;
    logic [3:0]  code_r;
    logic [1:0]  rstMask_r;
    logic        inFunc_r;
    logic [7:0]  swRdata_r;
    logic        busy;
    logic        rdIssued_r;
    logic        rdWait_r;
    logic [3:0]  echo_r;

    // Undecoded codes leave the device where it was, so they never count as a function.
    function automatic logic isFunction(input logic [3:0] code);
        isFunction = code inside {msc_pkg::CODE_CORE, msc_pkg::CODE_SERIAL, msc_pkg::CODE_EE_CFG,
                                  msc_pkg::CODE_RANDOM, msc_pkg::CODE_CIPHER, msc_pkg::CODE_KEY_AGREE,
                                  msc_pkg::CODE_IDENT, msc_pkg::CODE_PERM, msc_pkg::CODE_OVERWRITE};
    endfunction

    assign busy = (seq_r != SEQ_IDLE);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_r     <= SEQ_IDLE;
            code_r    <= msc_pkg::CODE_IDLE;
            rstMask_r <= 2'h0;
        end else begin
            unique case (seq_r)
                SEQ_IDLE: begin
                    if (swWr && swAddr == msc_pkg::HOST_CMD_ADDR) begin
                        code_r <= swWdata[3:0];
                        seq_r  <= (inFunc_r && swWdata[3:0] != msc_pkg::CODE_IDLE) ? SEQ_WR_IDLE : SEQ_WR_CODE;  // [R09]
                    end else if (swWr && swAddr == msc_pkg::HOST_RST_ADDR) begin
                        rstMask_r <= swWdata[1:0];
                        seq_r     <= SEQ_RST_SET;
                    end
                end
                SEQ_WR_IDLE:     seq_r <= SEQ_COMMIT_IDLE;
                SEQ_COMMIT_IDLE: seq_r <= SEQ_WR_CODE;
                SEQ_WR_CODE:     seq_r <= SEQ_COMMIT;
                SEQ_COMMIT:      seq_r <= SEQ_IDLE;
                SEQ_RST_SET:     seq_r <= SEQ_RST_CLR;
                SEQ_RST_CLR:     seq_r <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inFunc_r <= 1'b0;  // [R10]
        end else if (seq_r == SEQ_COMMIT_IDLE) begin
            inFunc_r <= 1'b0;
        end else if (seq_r == SEQ_COMMIT) begin
            inFunc_r <= isFunction(code_r);  // [R11] [R12]
        end
    end

    // ****************************************************************
    // Bus drive
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.addr  <= '0;
            bus.wdata <= 8'h00;
            bus.wr    <= 1'b0;
            bus.rd    <= 1'b0;
        end else begin
            bus.wr    <= 1'b0;
            bus.rd    <= 1'b0;
            bus.wdata <= 8'h00;
            unique case (seq_r)
                SEQ_WR_IDLE: begin
                    bus.addr  <= msc_pkg::MAIN_SEL_ADDR;
                    bus.wdata <= {4'h0, msc_pkg::CODE_IDLE};  // [R08]
                    bus.wr    <= 1'b1;
                end
                SEQ_COMMIT_IDLE: begin
                    bus.addr <= msc_pkg::COMMIT_ADDR;  // [R08]
                    bus.wr   <= 1'b1;
                end
                SEQ_WR_CODE: begin
                    bus.addr  <= msc_pkg::MAIN_SEL_ADDR;
                    bus.wdata <= {4'h0, code_r};
                    bus.wr    <= 1'b1;
                end
                SEQ_COMMIT: begin
                    bus.addr <= (code_r == msc_pkg::CODE_OVERWRITE) ? msc_pkg::OW_COMMIT_ADDR
                                                                   : msc_pkg::COMMIT_ADDR;
                    bus.wr   <= 1'b1;
                end
                SEQ_RST_SET: begin
                    bus.addr  <= msc_pkg::SOFT_RESET_ADDR;
                    bus.wdata <= {6'h00, rstMask_r};  // [R01] [R02]
                    bus.wr    <= 1'b1;
                end
                SEQ_RST_CLR: begin
                    bus.addr <= msc_pkg::SOFT_RESET_ADDR;  // [R01] [R02]
                    bus.wr   <= 1'b1;
                end
                SEQ_IDLE: begin
                    if (swRd && swAddr == msc_pkg::HOST_STAT_ADDR) begin
                        bus.addr <= msc_pkg::MAIN_SEL_ADDR;
                        bus.rd   <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Read back of the main select code
    // ****************************************************************
    // The device answers one cycle after the strobe, so the reply is caught two edges after issue.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdIssued_r <= 1'b0;
            rdWait_r   <= 1'b0;
            echo_r     <= msc_pkg::MAIN_SEL_RST;
        end else begin
            rdIssued_r <= (seq_r == SEQ_IDLE) && swRd && (swAddr == msc_pkg::HOST_STAT_ADDR);
            rdWait_r   <= rdIssued_r;
            if (rdWait_r) begin
                echo_r <= bus.rdata[3:0];  // [R05]
            end
        end
    end

    // ****************************************************************
    // Software read port
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            swRdata_r <= 8'h00;
        end else if (swRd) begin
            unique case (swAddr)
                msc_pkg::HOST_CMD_ADDR:  swRdata_r <= {4'h0, code_r};
                msc_pkg::HOST_STAT_ADDR: swRdata_r <= {2'h0, echo_r, inFunc_r, busy};
                default:                 swRdata_r <= 8'h00;
            endcase
        end else begin
            swRdata_r <= 8'h00;
        end
    end

    assign swRdata = swRdata_r;
endmodule

// >>> sim/msc_properties.sv
// Checker of the register link between the host and device ends.
`timescale 1ns/100ps
module msc_properties (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [16:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // The code waiting for a commit, and the last decoded code that a commit made current,
    // so that function codes can be tied to the idle state that must precede them.
    logic [3:0] pendCode_r;
    logic [3:0] lastCode_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            pendCode_r <= msc_pkg::MAIN_SEL_RST;
        else if (wr && addr == msc_pkg::MAIN_SEL_ADDR)
            pendCode_r <= wdata[3:0];
    end
    // An undecoded code that is committed moves nothing, so it is not tracked.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            lastCode_r <= msc_pkg::CODE_IDLE;
        else if ((wr || rd) && addr == msc_pkg::COMMIT_ADDR
                 && pendCode_r inside {msc_pkg::CODE_IDLE, msc_pkg::CODE_CORE, msc_pkg::CODE_SERIAL,
                                       msc_pkg::CODE_EE_CFG, msc_pkg::CODE_RANDOM, msc_pkg::CODE_CIPHER,
                                       msc_pkg::CODE_KEY_AGREE, msc_pkg::CODE_IDENT, msc_pkg::CODE_PERM,
                                       msc_pkg::CODE_OVERWRITE})
            lastCode_r <= pendCode_r;
        else if ((wr || rd) && addr == msc_pkg::OW_COMMIT_ADDR && pendCode_r == msc_pkg::CODE_OVERWRITE)
            lastCode_r <= pendCode_r;
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    strobe_excl_a: assert property (!(wr && rd))
        else $error("write and read strobes together");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without a read");
    access_read_a: assert property (rd && (addr == msc_pkg::COMMIT_ADDR || addr == msc_pkg::OW_COMMIT_ADDR)
        |=> rdata == 8'h00) else $error("access location returned data");
    main_upper_a: assert property (rd && addr == msc_pkg::MAIN_SEL_ADDR |=> rdata[7:4] == 4'h0)
        else $error("reserved main select bits not zero");
    ow_commit_a: assert property (wr && addr == msc_pkg::MAIN_SEL_ADDR && wdata[3:0] == msc_pkg::CODE_OVERWRITE
        |=> wr && addr == msc_pkg::OW_COMMIT_ADDR) else $error("overwrite code not committed");
    commit_follow_a: assert property (wr && addr == msc_pkg::MAIN_SEL_ADDR && wdata[3:0] != msc_pkg::CODE_OVERWRITE
        |=> wr && addr == msc_pkg::COMMIT_ADDR) else $error("code write not committed");
    reset_pulse_a: assert property (wr && addr == msc_pkg::SOFT_RESET_ADDR && wdata != 8'h00
        |=> wr && addr == msc_pkg::SOFT_RESET_ADDR && wdata == 8'h00) else $error("soft reset not released");
    idle_between_a: assert property (wr && addr == msc_pkg::MAIN_SEL_ADDR && wdata[3:0] != msc_pkg::CODE_IDLE
        |-> lastCode_r == msc_pkg::CODE_IDLE) else $error("function entered without idle");
endmodule

// >>> sim/main_state_control_test.sv
// Self-checking bench for both ends of the main state control link.
`timescale 1ns/100ps
module main_state_control_test;
    logic                core_clk;
    logic                rst_b;
    logic                swWr;
    logic                swRd;
    logic [1:0]          swAddr;
    logic [7:0]          swWdata;
    logic [7:0]          swRdata;
    logic [7:0]          rdVal;
    logic                functionActive;
    logic                eepromReset;
    logic                cipherReset;
    logic                seenEe;
    logic                seenCi;
    msc_pkg::msc_state_t mainState;
    int                  err_count = 0;
    int                  num_checks = 0;
    // Codes in the order of the state type, so a code's index is its state.
    int                  codes[10] = '{1, 5, 6, 7, 8, 9, 10, 11, 12, 15};
    msc_if link ();
    msc_device msc_device_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(link), .mainState(mainState),
        .functionActive(functionActive), .eepromReset(eepromReset), .cipherReset(cipherReset));
    msc_host msc_host_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(link), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
    msc_properties msc_properties_inst (.core_clk(core_clk), .rst_b(rst_b), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic swWrite(logic [1:0] a, logic [7:0] d);
        @(posedge core_clk);
        swWr <= 1'b1;
        swAddr <= a;
        swWdata <= d;
        @(posedge core_clk);
        swWr <= 1'b0;
    endtask
    task automatic swRead(logic [1:0] a);
        @(posedge core_clk);
        swRd <= 1'b1;
        swAddr <= a;
        @(posedge core_clk);
        swRd <= 1'b0;
        #1 rdVal = swRdata;
    endtask
    // A command sent while busy is dropped, so every command waits here.
    task automatic waitIdle();
        for (int i = 0; i < 40; i++) begin
            swRead(msc_pkg::HOST_STAT_ADDR);
            if (rdVal[0] === 1'b0)
                return;
        end
        err_count++;
        conclude();
    endtask
    task automatic runCode(int c);
        int idx;
        idx = 0;
        foreach (codes[k])
            if (codes[k] == c)
                idx = k;
        swWrite(msc_pkg::HOST_CMD_ADDR, 8'(c));
        waitIdle();
        chk({4'h0, mainState}, 8'(idx));
        chk({7'h0, functionActive}, {7'h0, idx != 0});
        chk({6'h0, rdVal[1:0]}, {6'h0, idx != 0, 1'b0});
        repeat (2) @(posedge core_clk);
        swRead(msc_pkg::HOST_STAT_ADDR);
        chk({4'h0, rdVal[5:2]}, 8'(c));
    endtask
    task automatic rstPulse(logic [1:0] m);
        seenEe = 1'b0;
        seenCi = 1'b0;
        swWrite(msc_pkg::HOST_RST_ADDR, {6'h0, m});
        waitIdle();
        chk({6'h0, seenEe, seenCi}, {6'h0, m});
        chk({6'h0, eepromReset, cipherReset}, 8'h00);
    endtask
    // ****************************************************************
    // Clock, monitors and main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (eepromReset === 1'b1)
            seenEe = 1'b1;
        if (cipherReset === 1'b1)
            seenCi = 1'b1;
    end
    initial begin
        rst_b = 1'b0;
        swWr = 1'b0;
        swRd = 1'b0;
        swAddr = 2'h0;
        swWdata = 8'h00;
        void'($urandom(32'h131B));
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        chk({4'h0, mainState}, 8'h00);
        chk({6'h0, eepromReset, cipherReset}, 8'h00);
        $display("test reset done");
        foreach (codes[k])
            runCode(codes[k]);
        runCode(3);
        runCode(5);
        runCode(15);
        runCode(0);
        $display("test codes done");
        for (int m = 1; m < 4; m++)
            rstPulse(2'(m));
        $display("test soft reset done");
        repeat (12) runCode(int'($urandom % 16));
        $display("test random done");
        // A reset in mid function must bring the state back to idle.
        runCode(9);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk({4'h0, mainState}, 8'h00);
        chk({7'h0, functionActive}, 8'h00);
        runCode(11);
        $display("test mid reset done");
        conclude();
    end
endmodule
